// [core/pec_pkg.sv]
`default_nettype none
package pec_pkg;

  // ********************************************************************
  // Widths and register offsets of the plain register port.
  // ********************************************************************
  localparam int unsigned CNT_W = 20;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 64;
  localparam logic [ADDR_W-1:0] REG_CTL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FETCH_CTL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PROC_CTX = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_SUM = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FETCH_STAT = 4'h5;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int unsigned CTL_A_LSB = 44;
  localparam int unsigned CTL_B_LSB = 6;
  localparam int unsigned CTL_MODE_BIT = 4;
  localparam int unsigned CTL_SEL_LSB = 2;
  localparam int unsigned FUC_SYS_EN_BIT = 0;
  localparam int unsigned FUC_A_EN_BIT = 1;
  localparam int unsigned FUC_B_EN_BIT = 2;
  localparam int unsigned PCX_PROC_EN_BIT = 0;
  localparam int unsigned FST_WIN_BIT = 3;

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic MODE_RST = 1'b0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ********************************************************************
  // Counting figures and timing counts in clock cycles.
  // ********************************************************************
  localparam logic [CNT_W-1:0] A_WRITE_BIAS = 20'h00004;
  localparam logic [3:0] RETIRE_MAX_ADD = 4'h8;
  localparam logic [2:0] OVERCOUNT_MAX = 3'h7;
  localparam int unsigned BCM_LEAD_CYC = 3;
  localparam int unsigned WIN_START_CYC = 5;
  localparam logic [2:0] OVR_CYC = 3'h2;
  localparam logic [2:0] PRE_LAST = 3'(WIN_START_CYC - 2);
  localparam logic [2:0] TAIL_LAST = 3'h1;

  // Input select encodings.
  localparam logic [1:0] SEL_RET_CYC = 2'h0;
  localparam logic [1:0] SEL_CYC_ALT = 2'h1;
  localparam logic [1:0] SEL_RET_BCM = 2'h2;
  localparam logic [1:0] SEL_CYC_RPL = 2'h3;

  typedef enum logic [2:0] {
    PEC_IDLE,
    PEC_ARMED,
    PEC_PRE,
    PEC_WIN,
    PEC_TAIL,
    PEC_DONE
  } pec_state_type;

endpackage
`default_nettype wire

// [core/pec_counter.sv]
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Free-running counter with load and a wrap flag for the add in flight.
// ********************************************************************
module pec_counter #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned INC_W = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic [INC_W-1:0] inc,
  output logic [WIDTH-1:0] count,
  output logic wrap
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH:0] sum;

  // The counter wraps through zero and keeps going; it never saturates.
  assign sum = {1'b0, count_q} + {{(WIDTH + 1 - INC_W){1'b0}}, inc};
  assign wrap = !load && sum[WIDTH];
  assign count = count_q;

  // A load wins over the add of the same cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else begin
      count_q <= sum[WIDTH-1:0];
    end
  end

endmodule // pec_counter
`default_nettype wire

// [core/pec_top.sv]
// Overview of operation
// - Mode bit: 0 aggregate, 1 profile.
// - Count needs own enable plus system/process enable.
// - Enabled overflow sets matching pending bit.
// - Cycle selection adds exactly one per cycle.
// - Retire adds at most eight, backlog kept.
// - Squashed instructions never count as retires.
// - Board-cache misses counted three cycles early.
// - Aggregate input select mapping of both counters.
// - Profile: counter A adds up to four fetches.
// - Overflowing fetch profiled; window opens cycle five.
// - Fetches in two post-overflow cycles reported, max seven.
// - Write to counter A stores value plus four.
// - Squashed no-ops still count as fetches.
// - Conditional move counts as two fetches.
// - Counters keep counting after overflow.
// - Window ends second cycle after end event.
// - Profile input select mapping of both counters.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pec_top
  import pec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [3:0] retire_cnt,
  input wire logic [3:0] retire_squash_cnt,
  input wire logic [2:0] fetch_valid_cnt,
  input wire logic bcache_miss,
  input wire logic replay_trap,
  input wire logic retire_delay,
  input wire logic prof_inst_end,
  output logic [1:0] counter_irq_pending,
  output logic window_active
);

  // ********************************************************************
  // Declarations.
  // ********************************************************************
  logic mode_select_bit_q;
  logic [1:0] input_select_pair_q;
  logic system_count_enable_q;
  logic counter_a_enable_q;
  logic counter_b_enable_q;
  logic process_count_enable_q;
  logic [1:0] counter_irq_enable_q;
  logic [1:0] counter_irq_pending_q;
  logic [1:0] pending_d;
  logic [4:0] backlog_q;
  logic [4:0] backlog_d;
  logic [2:0] bcm_dly_q;
  logic replay_dly_q;
  pec_state_type state_q;
  pec_state_type state_d;
  logic [2:0] phase_cnt_q;
  logic [2:0] overcount_field_q;
  logic [3:0] overcount_sum;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic window_q;
  logic ctl_wr;
  logic count_gate;
  logic a_go;
  logic b_go;
  logic in_win;
  logic a_fetching;
  logic a_counts_ret;
  logic [3:0] ret_net;
  logic [4:0] ret_pool;
  logic [3:0] ret_add;
  logic [3:0] a_inc;
  logic b_inc;
  logic [CNT_W-1:0] a_written;
  logic [CNT_W-1:0] a_load_val;
  logic [CNT_W-1:0] event_counter_a;
  logic [CNT_W-1:0] event_counter_b;
  logic wrap_a;
  logic wrap_b;
  logic wr_mode;
  logic [CNT_W-1:0] fetch_ext;

  // ********************************************************************
  // Enables and window decode.
  // ********************************************************************
  assign ctl_wr = reg_wr && (reg_addr == REG_CTL);
  assign count_gate = system_count_enable_q || process_count_enable_q;
  assign a_go = counter_a_enable_q && count_gate;
  assign b_go = counter_b_enable_q && count_gate;
  assign in_win = (state_q == PEC_WIN) || (state_q == PEC_TAIL);
  assign wr_mode = reg_wdata[CTL_MODE_BIT];
  assign fetch_ext = {{(CNT_W - 3){1'b0}}, fetch_valid_cnt};

  // Fetches are counted while armed and in the first two cycles after the
  // overflow; the fetch unit reports each half of a conditional move and
  // each squashed no-op as a fetch of its own.
  assign a_fetching = mode_select_bit_q && ((state_q == PEC_ARMED) ||
                      ((state_q == PEC_PRE) && (phase_cnt_q < OVR_CYC)));
  assign a_counts_ret = a_go && !input_select_pair_q[0] && !a_fetching &&
                        (!mode_select_bit_q || in_win);

  // ********************************************************************
  // Retire accounting with a backlog for bursts above eight.
  // ********************************************************************
  always_comb begin
    ret_net = (retire_cnt > retire_squash_cnt) ? (retire_cnt - retire_squash_cnt) : 4'h0;
    ret_pool = backlog_q + {1'b0, ret_net};
    ret_add = (ret_pool > {1'b0, RETIRE_MAX_ADD}) ? RETIRE_MAX_ADD : ret_pool[3:0];
    backlog_d = a_counts_ret ? (ret_pool - {1'b0, ret_add}) : 5'h00;
  end

  // The backlog cannot grow without bound because the pipeline cannot
  // sustain more than eight retires per cycle on average.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      backlog_q <= 5'h00;
    end else begin
      backlog_q <= backlog_d;
    end
  end

  // ********************************************************************
  // Increment selection for both counters.
  // ********************************************************************
  always_comb begin
    a_inc = 4'h0;
    if (a_go) begin
      if (a_fetching) begin
        a_inc = {1'b0, fetch_valid_cnt};
      end else if (!mode_select_bit_q || in_win) begin
        a_inc = input_select_pair_q[0] ? 4'h1 : ret_add;
      end
    end
  end

  // Counter B: cycles, retire delay, early-shifted misses or replay traps.
  always_comb begin
    b_inc = 1'b0;
    if (b_go && (!mode_select_bit_q || in_win)) begin
      unique case (input_select_pair_q)
        SEL_RET_CYC: b_inc = 1'b1;
        SEL_CYC_ALT: b_inc = mode_select_bit_q && retire_delay;
        SEL_RET_BCM: b_inc = bcm_dly_q[BCM_LEAD_CYC-1];
        SEL_CYC_RPL: b_inc = mode_select_bit_q ? replay_dly_q : replay_trap;
      endcase
    end
  end

  // Delaying the miss input against the window has the same effect as
  // opening the window three cycles early for it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bcm_dly_q <= 3'h0;
      replay_dly_q <= 1'b0;
    end else begin
      bcm_dly_q <= {bcm_dly_q[1:0], bcache_miss};
      replay_dly_q <= replay_trap;
    end
  end

  // ********************************************************************
  // Counters.
  // ********************************************************************
  assign a_written = reg_wdata[CTL_A_LSB +: CNT_W];
  assign a_load_val = a_written + A_WRITE_BIAS;

  // Both counters wrap and keep counting after an overflow.
  pec_counter #(
    .WIDTH(CNT_W),
    .INC_W(4)
  ) u_cnt_a (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(ctl_wr),
    .load_val(a_load_val),
    .inc(a_inc),
    .count(event_counter_a),
    .wrap(wrap_a)
  );

  pec_counter #(
    .WIDTH(CNT_W),
    .INC_W(1)
  ) u_cnt_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(ctl_wr),
    .load_val(reg_wdata[CTL_B_LSB +: CNT_W]),
    .inc(b_inc),
    .count(event_counter_b),
    .wrap(wrap_b)
  );

  // ********************************************************************
  // Profile window sequencer.
  // ********************************************************************
  always_comb begin
    state_d = state_q;
    if (ctl_wr) begin
      state_d = wr_mode ? PEC_ARMED : PEC_IDLE;
    end else begin
      unique case (state_q)
        PEC_IDLE: state_d = PEC_IDLE;
        PEC_ARMED: if (wrap_a) begin
          state_d = PEC_PRE;
        end
        PEC_PRE: if (phase_cnt_q == PRE_LAST) begin
          state_d = PEC_WIN;
        end
        PEC_WIN: if (prof_inst_end) begin
          state_d = PEC_TAIL;
        end
        PEC_TAIL: if (phase_cnt_q == TAIL_LAST) begin
          state_d = PEC_DONE;
        end
        PEC_DONE: state_d = PEC_DONE;
      endcase
    end
  end

  // Counter A stays idle after a window until the control register is
  // written again, so one sample cannot overwrite another.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= PEC_IDLE;
      phase_cnt_q <= 3'h0;
      window_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_cnt_q <= (state_d != state_q) ? 3'h0 : 3'(phase_cnt_q + 3'h1);
      window_q <= (state_d == PEC_WIN) || (state_d == PEC_TAIL);
    end
  end

  // Residual fetches of the two cycles after overflow, saturating.
  assign overcount_sum = {1'b0, overcount_field_q} + {1'b0, fetch_valid_cnt};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      overcount_field_q <= 3'h0;
    end else if (ctl_wr) begin
      overcount_field_q <= 3'h0;
    end else if (a_go && (state_q == PEC_PRE) && (phase_cnt_q < OVR_CYC)) begin
      overcount_field_q <= (overcount_sum > {1'b0, OVERCOUNT_MAX}) ? OVERCOUNT_MAX :
                           overcount_sum[2:0];
    end
  end

  // ********************************************************************
  // Control registers written by software.
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_select_bit_q <= MODE_RST;
      input_select_pair_q <= SEL_RST;
    end else if (ctl_wr) begin
      mode_select_bit_q <= wr_mode;
      input_select_pair_q <= reg_wdata[CTL_SEL_LSB +: 2];
    end
  end

  // Enable bits; the fetch unit, process context and interrupt enable words hold them.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      system_count_enable_q <= ENABLE_RST;
      counter_a_enable_q <= ENABLE_RST;
      counter_b_enable_q <= ENABLE_RST;
      process_count_enable_q <= ENABLE_RST;
      counter_irq_enable_q <= IRQ_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_FETCH_CTL) begin
        system_count_enable_q <= reg_wdata[FUC_SYS_EN_BIT];
        counter_a_enable_q <= reg_wdata[FUC_A_EN_BIT];
        counter_b_enable_q <= reg_wdata[FUC_B_EN_BIT];
      end
      if (reg_addr == REG_PROC_CTX) begin
        process_count_enable_q <= reg_wdata[PCX_PROC_EN_BIT];
      end
      if (reg_addr == REG_IRQ_EN) begin
        counter_irq_enable_q <= reg_wdata[1:0];
      end
    end
  end

  // Pending bits are cleared by writing ones; a set in the same cycle wins.
  always_comb begin
    pending_d = counter_irq_pending_q;
    if (reg_wr && (reg_addr == REG_IRQ_SUM)) begin
      pending_d = pending_d & ~reg_wdata[1:0];
    end
    pending_d = pending_d | ({wrap_b, wrap_a} & counter_irq_enable_q);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      counter_irq_pending_q <= IRQ_RST;
    end else begin
      counter_irq_pending_q <= pending_d;
    end
  end

  // ********************************************************************
  // Read port: data stands only in the cycle after the read strobe.
  // ********************************************************************
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTL: begin
          rdata_d[CTL_A_LSB +: CNT_W] = event_counter_a;
          rdata_d[CTL_B_LSB +: CNT_W] = event_counter_b;
          rdata_d[CTL_MODE_BIT] = mode_select_bit_q;
          rdata_d[CTL_SEL_LSB +: 2] = input_select_pair_q;
        end
        REG_FETCH_CTL: begin
          rdata_d[FUC_SYS_EN_BIT] = system_count_enable_q;
          rdata_d[FUC_A_EN_BIT] = counter_a_enable_q;
          rdata_d[FUC_B_EN_BIT] = counter_b_enable_q;
        end
        REG_PROC_CTX: rdata_d[PCX_PROC_EN_BIT] = process_count_enable_q;
        REG_IRQ_EN: rdata_d[1:0] = counter_irq_enable_q;
        REG_IRQ_SUM: rdata_d[1:0] = counter_irq_pending_q;
        REG_FETCH_STAT: begin
          rdata_d[2:0] = overcount_field_q;
          rdata_d[FST_WIN_BIT] = window_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign counter_irq_pending = counter_irq_pending_q;
  assign window_active = window_q;

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_hold_disabled: assert property ((!a_go && !ctl_wr) |=> $stable(event_counter_a))
    else $error("Counter A moved while disabled.");

  a_cycle_step: assert property ((a_go && !mode_select_bit_q && input_select_pair_q[0] && !ctl_wr)
    |=> event_counter_a == $past(event_counter_a) + 20'h00001)
    else $error("Cycle count did not add one.");

  a_retire_cap: assert property ((a_go && !mode_select_bit_q && !input_select_pair_q[0] && !ctl_wr)
    |=> (event_counter_a - $past(event_counter_a)) <= 20'h00008)
    else $error("Retire add exceeded eight.");

  a_squash_excluded: assert property ((a_counts_ret && !ctl_wr && backlog_q == 5'h00 &&
    retire_squash_cnt <= retire_cnt && (retire_cnt - retire_squash_cnt) <= 4'h8)
    |=> event_counter_a == $past(event_counter_a) + 20'($past(retire_cnt) - $past(retire_squash_cnt)))
    else $error("Squashed retires were counted.");

  a_pending_set: assert property ((wrap_a && counter_irq_enable_q[0]) |=> counter_irq_pending_q[0])
    else $error("Overflow did not set pending bit.");

  a_write_bias: assert property (ctl_wr |=> event_counter_a == $past(a_written) + A_WRITE_BIAS)
    else $error("Counter A write not biased by four.");

  a_mode_select: assert property (ctl_wr |=> mode_select_bit_q == $past(wr_mode) &&
    state_q == ($past(wr_mode) ? PEC_ARMED : PEC_IDLE))
    else $error("Mode bit did not select the counting mode.");

  a_fetch_accum: assert property ((state_q == PEC_ARMED && a_go && !ctl_wr && !wrap_a)
    |=> event_counter_a == $past(event_counter_a) + $past(fetch_ext))
    else $error("Fetch count not accumulated.");

  a_window_open: assert property ((state_q == PEC_ARMED && wrap_a && !ctl_wr) ##1 (!ctl_wr) [*4]
    |=> state_q == PEC_WIN && window_active)
    else $error("Window did not open on the fifth cycle.");

  a_window_close: assert property ((state_q == PEC_WIN && prof_inst_end && !ctl_wr) ##1 (!ctl_wr) [*2]
    |=> state_q == PEC_DONE && !window_active)
    else $error("Window did not close two cycles after its end.");

  a_miss_lead: assert property (bcache_miss ##3 (b_go && !mode_select_bit_q &&
    input_select_pair_q == SEL_RET_BCM && !ctl_wr) |=> event_counter_b == $past(event_counter_b) + 20'h00001)
    else $error("Early miss event not counted.");

  a_read_snapshot: assert property ((reg_rd && reg_addr == REG_CTL)
    |=> reg_rdata[CTL_A_LSB +: CNT_W] == $past(event_counter_a) &&
        reg_rdata[CTL_B_LSB +: CNT_W] == $past(event_counter_b))
    else $error("Control read is not a snapshot.");

endmodule // pec_top
`default_nettype wire

// [verification/pec_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ******
// Pipeline model: plays a burst of like event cycles.
// ******
module pec_pipe_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [3:0] ret,
  input wire logic [3:0] sq,
  input wire logic [2:0] fet,
  input wire logic [7:0] end_at,
  input wire logic window_active,
  output logic [3:0] retire_cnt,
  output logic [3:0] retire_squash_cnt,
  output logic [2:0] fetch_valid_cnt,
  output logic bcache_miss,
  output logic replay_trap,
  output logic retire_delay,
  output logic prof_inst_end
);
  logic [7:0] left_q;
  logic [7:0] win_q;
  logic on;

  // Cycles left in the burst; go reloads the count.
  always_ff @(posedge clk_sys) begin
    if (srst || go) begin
      left_q <= srst ? 8'h00 : len;
    end else if (on) begin
      left_q <= left_q - 8'h01;
    end
  end

  // Window age, so the end event lands on a chosen window cycle.
  always_ff @(posedge clk_sys) begin
    win_q <= (srst || !window_active) ? 8'h00 : win_q + 8'h01;
  end

  // Idle cycles carry no events, so a stray count shows up.
  assign on = (left_q != 8'h00);
  assign retire_cnt = on ? ret : 4'h0;
  assign retire_squash_cnt = on ? sq : 4'h0;
  assign fetch_valid_cnt = on ? fet : 3'h0;
  assign bcache_miss = on;
  assign replay_trap = on;
  assign retire_delay = on;
  // The tail after the end event is the device's job, not ours.
  assign prof_inst_end = window_active && (win_q == end_at - 8'h01);
endmodule // pec_pipe_model

`default_nettype wire

// [verification/pec_top_test.sv]
`timescale 1ns/1ps
`default_nettype none

// ******
// Self-checking bench for the event counter block.
// ******
module pec_top_test
  import pec_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [3:0] retire_cnt;
  logic [3:0] retire_squash_cnt;
  logic [2:0] fetch_valid_cnt;
  logic bcache_miss;
  logic replay_trap;
  logic retire_delay;
  logic prof_inst_end;
  logic [1:0] counter_irq_pending;
  logic window_active;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic [3:0] ret = 4'h0;
  logic [3:0] sq = 4'h0;
  logic [2:0] fet = 3'h0;
  logic [7:0] end_at = 8'h00;
  logic [DATA_W-1:0] v;
  int n_errors = 0;
  int num_checks = 0;

  pec_top u_pec_top (
    .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .retire_cnt, .retire_squash_cnt, .fetch_valid_cnt, .bcache_miss,
    .replay_trap, .retire_delay, .prof_inst_end, .counter_irq_pending,
    .window_active
  );

  pec_pipe_model u_pec_pipe_model (
    .clk_sys, .srst, .go, .len, .ret, .sq, .fet, .end_at, .window_active,
    .retire_cnt, .retire_squash_cnt, .fetch_valid_cnt, .bcache_miss,
    .replay_trap, .retire_delay, .prof_inst_end
  );

  // A 25 ns clock.
  always #12.5 clk_sys = ~clk_sys;

  // ******
  // Bus and compare helpers.
  // ******
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [63:0] ctl(input logic [19:0] a, input logic [19:0] b,
      input logic m, input logic [1:0] s);
    return (64'(a) << CTL_A_LSB) | (64'(b) << CTL_B_LSB) | (64'(m) << CTL_MODE_BIT) | (64'(s) << CTL_SEL_LSB);
  endfunction

  task automatic play(input logic [7:0] n);
    @(posedge clk_sys);
    go <= 1'b1;
    len <= n;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask

  // Counting stays enabled for w plus four cycles, then the control is read.
  task automatic burst(input logic [7:0] n, input int w);
    wr(REG_FETCH_CTL, 64'h7);
    play(n);
    tick(w);
    wr(REG_FETCH_CTL, 64'h0);
    rd(REG_CTL, v);
  endtask

  // ******
  // Scenarios.
  // ******
  task automatic t_reset();
    wr(4'hf, '1);
    for (int i = 0; i < 7; i++) begin
      rd(i < 6 ? ADDR_W'(i) : 4'hf, v);
      check(v, 64'h0);
    end
    check(64'({counter_irq_pending, window_active}), 64'h0);
  endtask

  task automatic t_enables();
    logic [2:0] fc [4] = '{3'h2, 3'h3, 3'h2, 3'h5};
    logic pc [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTL, ctl(20'h0, 20'h0, 1'b0, SEL_CYC_ALT));
      wr(REG_PROC_CTX, 64'(pc[i]));
      wr(REG_FETCH_CTL, 64'(fc[i]));
      tick(10);
      wr(REG_FETCH_CTL, 64'h0);
      rd(REG_CTL, v);
      check(64'(v[63:44]), (i == 1 || i == 2) ? 64'd16 : 64'd4);
    end
  endtask

  task automatic t_select();
    ret <= 4'h2;
    sq <= 4'h0;
    fet <= 3'h1;
    for (int s = 0; s < 4; s++) begin
      wr(REG_CTL, ctl(20'h0, 20'h0, 1'b0, 2'(s)));
      burst(8'd6, 12);
      check(64'(v[4:2]), 64'(s));
      check(64'(v[63:44]), s[0] ? 64'd20 : 64'd16);
      check(64'(v[25:6]), s == 0 ? 64'd16 : (s == 1 ? 64'd0 : 64'd6));
    end
  endtask

  // Bursts of eleven retires must be made up in later cycles.
  task automatic t_retire();
    ret <= 4'hb;
    wr(REG_CTL, ctl(20'h0, 20'h0, 1'b0, SEL_RET_CYC));
    burst(8'd3, 12);
    check(64'(v[63:44]), 64'd37);
    sq <= 4'h4;
    burst(8'd2, 12);
    check(64'(v[63:44]), 64'd51);
  endtask

  task automatic t_overflow();
    ret <= 4'h4;
    sq <= 4'h0;
    wr(REG_IRQ_EN, 64'h1);
    wr(REG_CTL, ctl(20'hffff0, 20'hffffc, 1'b0, SEL_RET_CYC));
    burst(8'd4, 6);
    check(64'(v[63:44]), 64'h4);
    check(64'(v[25:6]), 64'h6);
    check(64'(counter_irq_pending), 64'h1);
    tick(1);
    #1;
    check(reg_rdata, 64'h0);
    wr(REG_IRQ_SUM, 64'h3);
    rd(REG_IRQ_SUM, v);
    check(v, 64'h0);
  endtask

  // Four fetches a cycle: the third cycle wraps, two more saturate overcount.
  // Both window-only inputs of counter B are run: retire delay and late replay traps.
  // The six-cycle window adds six to both counters, on top of eight residual fetches.
  task automatic t_profile();
    int n;
    for (int s = 1; s < 4; s += 2) begin
      n = 1;
      play(8'd0);
      fet <= 3'h4;
      end_at <= 8'd4;
      wr(REG_CTL, ctl(20'hffff0, 20'h0, 1'b1, 2'(s)));
      wr(REG_FETCH_CTL, 64'h7);
      play(8'd40);
      tick(6);
      #1;
      check(64'(window_active), 64'h0);
      tick(1);
      #1;
      check(64'(window_active), 64'h1);
      repeat (100) begin
        tick(1);
        #1;
        if (window_active !== 1'b1) break;
        n++;
      end
      check(64'(n), 64'd6);
      rd(REG_FETCH_STAT, v);
      check(64'(v[3:0]), 64'h7);
      check(64'(counter_irq_pending), 64'h1);
      rd(REG_CTL, v);
      check(64'(v[4:2]), 64'(4 + s));
      check(64'(v[63:44]), 64'd14);
      check(64'(v[25:6]), 64'd6);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    tick(8);
    srst <= 1'b0;
    t_reset();
    t_enables();
    t_select();
    t_retire();
    t_overflow();
    t_profile();
    conclude();
  end

  // A hang is cut short well inside the cycle budget.
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end
endmodule // pec_top_test

`default_nettype wire
